// >>> mcr_core.sv
// Behaviour
// - gain code selects mirror gain range
// - gain code selects maximum current limit
// - sense valid only while low side conducts
// - sense disabled with the low-side off command
// - sense ready after delay, not on drive/brake
// - scheme 00 off-time, 01 cycle-by-cycle
// - scheme 1X: voltage/speed regulation, no current
// - trip when sensed voltage meets reference
// - internal reference select uses fixed reference
// - blank trip after each output switching
// - trip must persist for deglitch time
// - limit mode 00 never regulates
// - limit mode 01: inrush only if stall enabled
// - limit mode 1X regulates always
// - off-time brake, input change ends it
// - cbc brake until next pin edge or register bit rise
// - cbc report pulls fault low while regulating
`include "mcr_regs.svh"
`default_nettype none
// ==========================================================
// current sense and regulation control
module mcr_core #(
	parameter int OFF_CYC = (`MCR_T_OFF_NS * `MCR_CLK_MHZ) / 1000,
	parameter int INRUSH_LSB_CYC = (`MCR_T_INRUSH_LSB_NS * `MCR_CLK_MHZ)
		/ 1000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [31:0] rdData,
	// bridge input pins
	input wire logic bridgeInputA,
	input wire logic bridgeInputB,
	// trip comparators, against pin and internal reference
	input wire logic tripCmpPinRef,
	input wire logic tripCmpIntRef,
	// bridge gate commands
	output logic highSideOnA,
	output logic highSideOnB,
	output logic lowSideOnA,
	output logic lowSideOnB,
	// sense output control
	output logic senseCurrentOutputEn,
	output logic senseReady,
	output mcr_pkg::mcr_gain_type mirrorGain,
	output logic [2:0] currentLimitIdx,
	output logic intRefSel,
	// status
	output logic voltageRegMode,
	output logic faultIndicatorN,
	output logic irq
);
	localparam int BLANK_CYC = (`MCR_T_BLANK_NS * `MCR_CLK_MHZ + 999) / 1000;
	localparam int DEG_CYC = (`MCR_T_DEG_NS * `MCR_CLK_MHZ + 999) / 1000;
	localparam int DELAY_CYC = (`MCR_T_DELAY_NS * `MCR_CLK_MHZ + 999) / 1000;

	typedef struct packed {
		logic [1:0] pinA;
		logic [1:0] pinB;
		logic [1:0] tripPin;
		logic [1:0] tripInt;
		logic prevA;
		logic prevB;
		logic prevReqDrive;
		logic started;
		logic prevInrush;
		logic [`MCR_CTRL_W-1:0] ctrl;
		logic [`MCR_INT_W-1:0] intStat;
		logic [`MCR_INT_W-1:0] intMask;
		logic [15:0] inrushSet;
		logic [15:0] pre;
		mcr_pkg::mcr_reg_state_type regState;
		mcr_pkg::mcr_drive_type drive;
		logic lowA;
		logic lowB;
		logic highA;
		logic highB;
		logic senseEn;
		logic senseReady;
		logic faultN;
		logic irq;
		logic voltMode;
		mcr_pkg::mcr_gain_type gain;
		logic [2:0] limitIdx;
		logic intRef;
		logic [31:0] rdData;
	} mcr_state_type;

	localparam mcr_state_type RST = '{
		ctrl: `MCR_CTRL_RST,
		inrushSet: `MCR_INRUSH_RST,
		faultN: 1'b1,
		regState: mcr_pkg::MCR_FOLLOW,
		drive: mcr_pkg::MCR_COAST,
		gain: mcr_pkg::MCR_GAIN_225,
		default: '0
	};

	mcr_state_type s;
	mcr_state_type n;

	// timer controls and status
	logic blankLoad, blankBusy;
	logic degLoad, degBusy;
	logic delayLoad, delayBusy;
	logic offLoad, offBusy;
	logic inrushLoad, inrushBusy;
	logic preTick;

	// ==========================================================
	// helper functions
	function automatic mcr_pkg::mcr_drive_type decodeDrive(
		input logic pwm, input logic a, input logic b);
		mcr_pkg::mcr_drive_type d;
		d = mcr_pkg::MCR_COAST;
		if (pwm) begin
			case ({a, b})
				2'b00: d = mcr_pkg::MCR_COAST;
				2'b01: d = mcr_pkg::MCR_REV;
				2'b10: d = mcr_pkg::MCR_FWD;
				default: d = mcr_pkg::MCR_BRAKE;
			endcase
		end else begin
			// a is enable, b is phase
			if (!a) begin
				d = mcr_pkg::MCR_BRAKE;
			end else if (b) begin
				d = mcr_pkg::MCR_FWD;
			end else begin
				d = mcr_pkg::MCR_REV;
			end
		end
		return d;
	endfunction

	function automatic logic isDrive(input mcr_pkg::mcr_drive_type d);
		return (d == mcr_pkg::MCR_FWD) || (d == mcr_pkg::MCR_REV);
	endfunction

	function automatic mcr_pkg::mcr_gain_type gainOf(input logic [2:0] c);
		mcr_pkg::mcr_gain_type g;
		g = mcr_pkg::MCR_GAIN_5560;
		case (c[2:1])
			2'b00: g = mcr_pkg::MCR_GAIN_225;
			2'b01: g = mcr_pkg::MCR_GAIN_1125;
			default: g = mcr_pkg::MCR_GAIN_5560;
		endcase
		return g;
	endfunction

	// limit index 0..5 = 4, 2, 1, 0.5, 0.25, 0.125 A
	function automatic logic [2:0] limitOf(input logic [2:0] c);
		return c[2] ? {2'b10, c[0]} : c;
	endfunction

	// ==========================================================
	// timers
	mcr_timer #(.W(16)) uBlank (
		.clk_sys(clk_sys), .rstn(rstn), .load(blankLoad),
		.loadVal(16'(BLANK_CYC)), .tick(1'b1), .busy(blankBusy)
	);
	mcr_timer #(.W(16)) uDeg (
		.clk_sys(clk_sys), .rstn(rstn), .load(degLoad),
		.loadVal(16'(DEG_CYC)), .tick(1'b1), .busy(degBusy)
	);
	mcr_timer #(.W(16)) uDelay (
		.clk_sys(clk_sys), .rstn(rstn), .load(delayLoad),
		.loadVal(16'(DELAY_CYC)), .tick(1'b1), .busy(delayBusy)
	);
	mcr_timer #(.W(16)) uOff (
		.clk_sys(clk_sys), .rstn(rstn), .load(offLoad),
		.loadVal(16'(OFF_CYC)), .tick(1'b1), .busy(offBusy)
	);
	mcr_timer #(.W(16)) uInrush (
		.clk_sys(clk_sys), .rstn(rstn), .load(inrushLoad),
		.loadVal(s.inrushSet), .tick(preTick), .busy(inrushBusy)
	);

	// ==========================================================
	// next-state logic
	always_comb begin
		logic effA;
		logic effB;
		logic cbcEdge;
		logic inChange;
		logic trip;
		logic tripQ;
		logic allowed;
		logic evReg;
		logic [`MCR_INT_W-1:0] ev;
		logic [`MCR_INT_W-1:0] clr;
		mcr_pkg::mcr_drive_type req;
		effA = 1'b0;
		effB = 1'b0;
		cbcEdge = 1'b0;
		inChange = 1'b0;
		trip = 1'b0;
		tripQ = 1'b0;
		allowed = 1'b0;
		evReg = 1'b0;
		ev = '0;
		clr = '0;
		req = mcr_pkg::MCR_COAST;
		n = s;
		offLoad = 1'b0;

		// two-stage synchronisers
		n.pinA = {s.pinA[0], bridgeInputA};
		n.pinB = {s.pinB[0], bridgeInputB};
		n.tripPin = {s.tripPin[0], tripCmpPinRef};
		n.tripInt = {s.tripInt[0], tripCmpIntRef};

		// bridge inputs from pins or register bits
		effA = s.ctrl[`MCR_F_BRSRC] ? s.ctrl[`MCR_F_REGA] : s.pinA[1];
		effB = s.ctrl[`MCR_F_BRSRC] ? s.ctrl[`MCR_F_REGB] : s.pinB[1];
		inChange = (effA != s.prevA) || (effB != s.prevB);
		if (s.ctrl[`MCR_F_BRSRC]) begin
			cbcEdge = (effA && !s.prevA) || (effB && !s.prevB);
		end else begin
			cbcEdge = inChange;
		end
		n.prevA = effA;
		n.prevB = effB;
		req = decodeDrive(s.ctrl[`MCR_F_PWM], effA, effB);

		// reference select, blanking and deglitch qualify the trip
		trip = s.ctrl[`MCR_F_INTREF] ? s.tripInt[1] : s.tripPin[1];
		tripQ = trip && !blankBusy && !degBusy;

		// limit mode and scheme decide if regulation may act
		case (s.ctrl[`MCR_F_LIMIT])
			`MCR_LIMIT_NONE: allowed = 1'b0;
			`MCR_LIMIT_INRUSH: begin
				allowed = s.ctrl[`MCR_F_STALLEN] ? inrushBusy : 1'b1;
			end
			default: allowed = 1'b1;
		endcase
		if (s.ctrl[`MCR_F_VOLT]) begin
			allowed = 1'b0;
		end

		// regulation state machine
		case (s.regState)
			mcr_pkg::MCR_FOLLOW: begin
				if (allowed && tripQ && isDrive(req)) begin
					evReg = 1'b1;
					if (s.ctrl[`MCR_F_SCHEME] == `MCR_SCHEME_OFFTIME) begin
						n.regState = mcr_pkg::MCR_OFFTIME;
						offLoad = 1'b1;
					end else begin
						n.regState = mcr_pkg::MCR_HOLD;
					end
				end
			end
			mcr_pkg::MCR_OFFTIME: begin
				if (inChange || !allowed) begin
					n.regState = mcr_pkg::MCR_FOLLOW;
				end else if (!offBusy) begin
					if (trip) begin
						offLoad = 1'b1;
					end else begin
						n.regState = mcr_pkg::MCR_FOLLOW;
					end
				end
			end
			mcr_pkg::MCR_HOLD: begin
				if (cbcEdge || !allowed) begin
					n.regState = mcr_pkg::MCR_FOLLOW;
				end
			end
			default: n.regState = mcr_pkg::MCR_FOLLOW;
		endcase

		// regulation overrides the inputs with brake
		n.drive = (n.regState == mcr_pkg::MCR_FOLLOW) ? req :
			mcr_pkg::MCR_BRAKE;
		n.highA = (n.drive == mcr_pkg::MCR_FWD);
		n.highB = (n.drive == mcr_pkg::MCR_REV);
		n.lowA = (n.drive == mcr_pkg::MCR_REV) ||
			(n.drive == mcr_pkg::MCR_BRAKE);
		n.lowB = (n.drive == mcr_pkg::MCR_FWD) ||
			(n.drive == mcr_pkg::MCR_BRAKE);

		// sense follows the low-side command in the same cycle
		n.senseEn = n.lowA || n.lowB;
		n.senseReady = n.senseEn && s.senseEn && !delayBusy;
		n.faultN = !((n.regState == mcr_pkg::MCR_HOLD) &&
			s.ctrl[`MCR_F_REPORT]);

		// startup period restarts when driving begins
		n.prevReqDrive = isDrive(req);
		n.started = 1'b1;
		n.prevInrush = inrushBusy;
		n.pre = preTick ? 16'h0000 : s.pre + 16'h0001;

		// configuration outputs
		n.gain = gainOf(s.ctrl[`MCR_F_GAIN]);
		n.limitIdx = limitOf(s.ctrl[`MCR_F_GAIN]);
		n.intRef = s.ctrl[`MCR_F_INTREF];
		n.voltMode = s.ctrl[`MCR_F_VOLT];

		// register writes take effect next cycle
		if (wrEn) begin
			case (regAddr)
				`MCR_ADDR_CTRL: n.ctrl = wrData[`MCR_CTRL_W-1:0];
				`MCR_ADDR_INT_STAT: clr = wrData[`MCR_INT_W-1:0];
				`MCR_ADDR_INT_MASK: n.intMask = wrData[`MCR_INT_W-1:0];
				`MCR_ADDR_INRUSH: n.inrushSet = wrData[15:0];
				default: ;
			endcase
		end

		// sticky events, set wins over write-one-clear
		ev[`MCR_EV_REG] = evReg;
		ev[`MCR_EV_READY] = n.senseReady && !s.senseReady;
		ev[`MCR_EV_INRUSH] = s.prevInrush && !inrushBusy;
		n.intStat = (s.intStat & ~clr) | ev;
		n.irq = |(n.intStat & n.intMask);

		// read data stand one cycle only
		n.rdData = '0;
		if (rdEn) begin
			case (regAddr)
				`MCR_ADDR_CTRL: n.rdData = {18'h0_0000, s.ctrl};
				`MCR_ADDR_STATUS: begin
					n.rdData = {22'h00_0000, s.voltMode, s.faultN,
						inrushBusy, allowed, tripQ, s.senseReady,
						s.regState, s.drive};
				end
				`MCR_ADDR_INT_STAT: n.rdData = {29'h0000_0000, s.intStat};
				`MCR_ADDR_INT_MASK: n.rdData = {29'h0000_0000, s.intMask};
				`MCR_ADDR_INRUSH: n.rdData = {16'h0000, s.inrushSet};
				default: n.rdData = '0;
			endcase
		end
	end

	// ==========================================================
	// timer load terms
	assign blankLoad = (n.drive != s.drive);
	assign degLoad = blankBusy ||
		!(s.ctrl[`MCR_F_INTREF] ? s.tripInt[1] : s.tripPin[1]);
	assign delayLoad = n.senseEn && !s.senseEn;
	assign inrushLoad = !s.started || (n.prevReqDrive && !s.prevReqDrive);
	assign preTick = (s.pre == 16'(INRUSH_LSB_CYC - 1));

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s <= RST;
		end else begin
			s <= n;
		end
	end

	// ==========================================================
	// outputs straight from flops
	assign rdData = s.rdData;
	assign highSideOnA = s.highA;
	assign highSideOnB = s.highB;
	assign lowSideOnA = s.lowA;
	assign lowSideOnB = s.lowB;
	assign senseCurrentOutputEn = s.senseEn;
	assign senseReady = s.senseReady;
	assign mirrorGain = s.gain;
	assign currentLimitIdx = s.limitIdx;
	assign intRefSel = s.intRef;
	assign voltageRegMode = s.voltMode;
	assign faultIndicatorN = s.faultN;
	assign irq = s.irq;
endmodule
`default_nettype wire

// >>> mcr_regs.svh
// ==========================================================
// register map, field positions, reset values, timing
`ifndef MCR_REGS_SVH
`define MCR_REGS_SVH

// ==========================================================
// register offsets
`define MCR_ADDR_CTRL 8'h00
`define MCR_ADDR_STATUS 8'h04
`define MCR_ADDR_INT_STAT 8'h08
`define MCR_ADDR_INT_MASK 8'h0C
`define MCR_ADDR_INRUSH 8'h10

// ==========================================================
// control register fields
`define MCR_CTRL_W 14
`define MCR_F_GAIN 2:0
`define MCR_F_SCHEME 4:3
`define MCR_F_VOLT 4
`define MCR_F_LIMIT 6:5
`define MCR_F_INTREF 7
`define MCR_F_STALLEN 8
`define MCR_F_REPORT 9
`define MCR_F_BRSRC 10
`define MCR_F_PWM 11
`define MCR_F_REGA 12
`define MCR_F_REGB 13
`define MCR_CTRL_RST 14'h0840

// ==========================================================
// interrupt bits
`define MCR_INT_W 3
`define MCR_EV_REG 0
`define MCR_EV_READY 1
`define MCR_EV_INRUSH 2

// ==========================================================
// scheme and limit mode encodings
`define MCR_SCHEME_OFFTIME 2'h0
`define MCR_SCHEME_CBC 2'h1
`define MCR_LIMIT_NONE 2'h0
`define MCR_LIMIT_INRUSH 2'h1

// ==========================================================
// startup period, in ticks of one lsb
`define MCR_INRUSH_RST 16'h2625

// ==========================================================
// timing
`define MCR_CLK_MHZ 250
`define MCR_T_BLANK_NS 1800
`define MCR_T_DEG_NS 1000
`define MCR_T_DELAY_NS 2000
`define MCR_T_OFF_NS 20000
`define MCR_T_INRUSH_LSB_NS 102400

`endif

// >>> mcr_pkg.sv
`default_nettype none
// ==========================================================
// shared types of the current regulation block
package mcr_pkg;
	typedef enum logic [1:0] {MCR_COAST, MCR_FWD, MCR_REV, MCR_BRAKE}
		mcr_drive_type;
	typedef enum logic [1:0] {MCR_FOLLOW, MCR_OFFTIME, MCR_HOLD}
		mcr_reg_state_type;
	typedef enum logic [1:0] {MCR_GAIN_225, MCR_GAIN_1125, MCR_GAIN_5560}
		mcr_gain_type;
endpackage
`default_nettype wire

// >>> mcr_timer.sv
`default_nettype none
// ==========================================================
// down counter; busy while the count is not zero
module mcr_timer #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// control
	input wire logic load,
	input wire logic [W-1:0] loadVal,
	input wire logic tick,
	// status
	output logic busy
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic busy;
	} mcr_timer_state_type;

	mcr_timer_state_type s;
	mcr_timer_state_type n;

	// load wins over counting
	always_comb begin
		n = s;
		if (load) begin
			n.cnt = loadVal;
		end else if (tick && s.cnt != '0) begin
			n.cnt = s.cnt - 1'b1;
		end
		n.busy = (n.cnt != '0);
	end

	// state register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign busy = s.busy;
endmodule
`default_nettype wire

// >>> mcr_core_sva.sv
`default_nettype none
// ==========
// port checker of the current regulation block
module mcr_core_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// register writes
	input wire logic [7:0] regAddr,
	input wire logic [31:0] wrData,
	input wire logic wrEn,
	// trip comparators and gates
	input wire logic tripCmpPinRef,
	input wire logic tripCmpIntRef,
	input wire logic highSideOnA,
	input wire logic highSideOnB,
	input wire logic lowSideOnA,
	input wire logic lowSideOnB,
	// sense and status
	input wire logic senseCurrentOutputEn,
	input wire logic senseReady,
	input wire mcr_pkg::mcr_gain_type mirrorGain,
	input wire logic [2:0] currentLimitIdx,
	input wire logic intRefSel,
	input wire logic voltageRegMode,
	input wire logic faultIndicatorN
);
	logic [13:0] ctl_ff;
	logic [9:0] onCnt_ff, tripCnt_ff, stillCnt_ff;
	logic [3:0] gates_ff;
	wire logic [3:0] gates = {highSideOnA, highSideOnB, lowSideOnA, lowSideOnB};
	wire logic trip = ctl_ff[7] ? tripCmpIntRef : tripCmpPinRef;
	// shadow control word and saturating run-length counters
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctl_ff <= 14'h0840;
			onCnt_ff <= 10'h000;
			tripCnt_ff <= 10'h000;
			stillCnt_ff <= 10'h000;
			gates_ff <= 4'h0;
		end else begin
			if (wrEn && regAddr == 8'h00)
				ctl_ff <= wrData[13:0];
			onCnt_ff <= senseCurrentOutputEn ?
				onCnt_ff + {9'h000, ~&onCnt_ff} : 10'h000;
			tripCnt_ff <= trip ? tripCnt_ff + {9'h000, ~&tripCnt_ff} : 10'h000;
			stillCnt_ff <= (gates == gates_ff) ?
				stillCnt_ff + {9'h000, ~&stillCnt_ff} : 10'h000;
			gates_ff <= gates;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sense_gate_a:
		assert property (senseCurrentOutputEn == (lowSideOnA | lowSideOnB))
		else $error("sense enable differs from low side gates");
	sense_off_a:
		assert property (!senseCurrentOutputEn |-> !senseReady)
		else $error("sense ready while sense disabled");
	sense_delay_a:
		assert property ($rose(senseReady) |->
			onCnt_ff inside {[10'h1F3:10'h1F6]})
		else $error("sense ready rose off the delay");
	gain_map_a:
		assert property (mirrorGain ==
			($past(ctl_ff[2]) ? 2'h2 : {1'b0, $past(ctl_ff[1])}))
		else $error("mirror gain does not follow gain code");
	limit_map_a:
		assert property (currentLimitIdx == ($past(ctl_ff[2]) ?
			{2'h2, $past(ctl_ff[0])} : $past(ctl_ff[2:0])))
		else $error("current limit does not follow gain code");
	ref_sel_a:
		assert property (intRefSel == $past(ctl_ff[7]))
		else $error("reference select does not follow control");
	volt_mode_a:
		assert property (voltageRegMode == $past(ctl_ff[4]))
		else $error("voltage mode does not follow scheme");
	fault_brake_a:
		assert property (!faultIndicatorN |-> lowSideOnA && lowSideOnB
			&& !highSideOnA && !highSideOnB)
		else $error("fault low outside the brake hold");
	trip_deg_a:
		assert property ($fell(faultIndicatorN) |-> tripCnt_ff >= 10'h0FA)
		else $error("regulation entered on a short trip");
	trip_blank_a:
		assert property ($fell(faultIndicatorN) |-> stillCnt_ff >= 10'h1C1)
		else $error("regulation entered inside blanking");
	no_limit_a:
		assert property ((ctl_ff[6:5] == 2'h0) [*3] |-> faultIndicatorN)
		else $error("regulation with limit mode off");
endmodule
bind mcr_core mcr_core_sva u_sva (.clk_sys, .rstn, .regAddr, .wrData,
	.wrEn, .tripCmpPinRef, .tripCmpIntRef, .highSideOnA, .highSideOnB,
	.lowSideOnA, .lowSideOnB, .senseCurrentOutputEn, .senseReady,
	.mirrorGain, .currentLimitIdx, .intRefSel, .voltageRegMode,
	.faultIndicatorN);
`default_nettype wire

// >>> mcr_motor_model.sv
`default_nettype none
// ==========
// far side: a crude motor current seen by two trip comparators
module mcr_motor_model #(
	parameter int PIN_THR = 40,
	parameter int INT_THR = 20
) (
	// clock
	input wire logic clk_sys,
	// gates from the bridge
	input wire logic highSideOnA,
	input wire logic highSideOnB,
	input wire logic lowSideOnA,
	input wire logic lowSideOnB,
	// comparator results
	output logic tripCmpPinRef,
	output logic tripCmpIntRef
);
	int amps = 0;
	// current ramps while driven, decays in brake, freewheels away in coast
	always @(posedge clk_sys) begin
		if (highSideOnA || highSideOnB)
			amps <= (amps < 1000) ? amps + 1 : amps;
		else if (lowSideOnA && lowSideOnB)
			amps <= (amps > 0) ? amps - 1 : 0;
		else
			amps <= 0;
	end
	// comparators trip once the current meets the reference
	assign tripCmpPinRef = amps >= PIN_THR;
	assign tripCmpIntRef = amps >= INT_THR;
endmodule
`default_nettype wire

// >>> mcr_core_tb.sv
`default_nettype none
// ==========
// bench of the current regulation block
module mcr_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] wrData = 32'h0000_0000;
	logic wrEn = 1'b0;
	logic rdEn = 1'b0;
	logic pinA = 1'b0;
	logic pinB = 1'b0;
	wire logic [31:0] rdData;
	wire logic tripP, tripI, hA, hB, lA, lB, senseEn, senseRdy;
	wire logic [2:0] limIdx;
	wire logic intRef, vMode, faultN, irq;
	wire mcr_pkg::mcr_gain_type gain;
	int errors = 0;
	int comparisons = 0;
	int i, m;
	logic [31:0] v;
	localparam logic [7:0] ADR [5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14};
	localparam logic [15:0] RST [5] = '{16'h0840, 16'h0000, 16'h0000,
		16'h2625, 16'h0000};
	localparam logic [1:0] LIM [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
	// clock
	initial forever #2 clk_sys = ~clk_sys;
	// design with shortened off time and startup tick
	mcr_core #(.OFF_CYC(20), .INRUSH_LSB_CYC(4)) u_dut (.clk_sys, .rstn,
		.regAddr, .wrData, .wrEn, .rdEn, .rdData, .bridgeInputA(pinA),
		.bridgeInputB(pinB), .tripCmpPinRef(tripP), .tripCmpIntRef(tripI),
		.highSideOnA(hA), .highSideOnB(hB), .lowSideOnA(lA), .lowSideOnB(lB),
		.senseCurrentOutputEn(senseEn), .senseReady(senseRdy),
		.mirrorGain(gain), .currentLimitIdx(limIdx), .intRefSel(intRef),
		.voltageRegMode(vMode), .faultIndicatorN(faultN), .irq);
	// motor and comparators
	mcr_motor_model u_motor (.clk_sys, .highSideOnA(hA), .highSideOnB(hB),
		.lowSideOnA(lA), .lowSideOnB(lB), .tripCmpPinRef(tripP),
		.tripCmpIntRef(tripI));
	// bus, pin, wait and compare helpers
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		wrData <= {16'h0000, d};
		wrEn <= 1'b1;
		@(posedge clk_sys);
		wrEn <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		rdEn <= 1'b1;
		@(posedge clk_sys);
		rdEn <= 1'b0;
		#1 v = rdData;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic pins(input logic a, input logic b);
		@(posedge clk_sys);
		pinA <= a;
		pinB <= b;
	endtask
	task automatic close_out();
		$display("counts: %0d compared, %0d wrong", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		for (i = 0; i < 5; i++) begin
			rd(ADR[i]);
			chk(v, {16'h0000, RST[i]});
		end
		wr(8'h0C, 16'h0007);
		rd(8'h0C);
		chk(v, 32'h0000_0007);
		$display("reset values done");
		for (i = 0; i < 8; i++) begin
			wr(8'h00, {8'h08, i[0], 2'h2, i[2], 1'b0, i[2:0]});
			cyc(1);
			chk({30'h0, gain}, {30'h0, i[2] ? 2'h2 : {1'b0, i[1]}});
			chk({29'h0, limIdx}, {29'h0, i[2] ? {2'h2, i[0]} : i[2:0]});
			chk({30'h0, intRef, vMode}, {30'h0, i[0], i[2]});
		end
		$display("gain codes done");
		wr(8'h10, 16'h0032);
		wr(8'h0C, 16'h0000);
		wr(8'h00, 16'h0840);
		pins(1'b1, 1'b0);
		for (i = 0; i < 1500 && (lA & lB) !== 1'b1; i++)
			cyc(1);
		chk({28'h0, hA, hB, lA, lB}, 32'h0000_0003);
		pins(1'b0, 1'b1);
		cyc(4);
		chk({28'h0, hA, hB, lA, lB}, 32'h0000_0006);
		chk({31'h0, irq}, 32'h0000_0000);
		rd(8'h08);
		chk(v & 32'h0000_0001, 32'h0000_0001);
		wr(8'h0C, 16'h0001);
		cyc(1);
		chk({31'h0, irq}, 32'h0000_0001);
		pins(1'b0, 1'b0);
		cyc(10);
		wr(8'h08, 16'h0007);
		cyc(1);
		chk({31'h0, irq}, 32'h0000_0000);
		$display("off-time done");
		for (m = 0; m < 5; m++) begin
			pins(1'b0, 1'b0);
			wr(8'h00, 16'h0A88 | {9'h0, LIM[m], 5'h0} | {7'h0, m[0], 8'h0});
			cyc(4);
			chk({30'h0, senseEn, senseRdy}, 32'h0000_0000);
			pins(1'b1, 1'b0);
			cyc(520);
			chk({31'h0, senseRdy}, 32'h0000_0001);
			for (i = 0; i < 1000 && faultN !== 1'b0; i++)
				cyc(1);
			chk({31'h0, faultN}, {31'h0, m < 2});
			if (m >= 2) begin
				cyc(30);
				chk({28'h0, hA, hB, lA, lB}, 32'h0000_0003);
				pins(1'b0, 1'b1);
				cyc(4);
				chk({27'h0, faultN, hA, hB, lA, lB}, 32'h0000_0016);
			end
			$display("limit mode case %0d done", m);
		end
		// bridge from register bits, cbc released by a 0-to-1 bit change
		wr(8'h00, 16'h1EC8);
		for (i = 0; i < 1000 && faultN !== 1'b0; i++)
			cyc(1);
		chk({27'h0, faultN, hA, hB, lA, lB}, 32'h0000_0003);
		rd(8'h04);
		chk(v, 32'h0000_005B);
		wr(8'h00, 16'h0EC8);
		cyc(4);
		chk({27'h0, faultN, hA, hB, lA, lB}, 32'h0000_0003);
		wr(8'h00, 16'h2EC8);
		cyc(2);
		chk({27'h0, faultN, hA, hB, lA, lB}, 32'h0000_0016);
		$display("register input cases done");
		// voltage scheme must not regulate current
		wr(8'h00, 16'h1ED0);
		cyc(800);
		chk({27'h0, faultN, hA, hB, lA, lB}, 32'h0000_0019);
		// enable/phase decode: brake, forward, reverse
		wr(8'h00, 16'h0410);
		cyc(2);
		chk({27'h0, senseEn, hA, hB, lA, lB}, 32'h0000_0013);
		wr(8'h00, 16'h3410);
		cyc(2);
		chk({27'h0, senseEn, hA, hB, lA, lB}, 32'h0000_0019);
		wr(8'h00, 16'h1410);
		cyc(2);
		chk({27'h0, senseEn, hA, hB, lA, lB}, 32'h0000_0016);
		$display("voltage and enable mode done");
		close_out();
	end
	// cut a hang short
	initial begin
		#160000;
		errors++;
		close_out();
	end
endmodule
`default_nettype wire
